/* File: design/clls_load_switch.sv */
// Charge-level load switch: validates state-of-charge packets, runs the
// shutdown/activation hysteresis, warning beeps, button and alarms.
// Assumes packets arrive already framed with an error flag from a receiver
// on the same clock; knobs, jumpers and button are asynchronous pins.
`timescale 1ns/1ps

module clls_load_switch (
  // Clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_in,
  // Received packet, one-cycle strobe from the line receiver
  input  wire logic                        pkt_valid_in,
  input  wire logic                        pkt_error_in,
  input  wire logic [clls_pkg::SOC_W-1:0]  pkt_soc_in,
  input  wire logic [clls_pkg::ID_W-1:0]   pkt_gen_id_in,
  input  wire logic [clls_pkg::ID_W-1:0]   pkt_surplus_id_in,
  input  wire logic                        pkt_day_in,
  // Front panel pins
  input  wire logic [clls_pkg::KNOB_W-1:0] shutdown_threshold_knob_in,
  input  wire logic [clls_pkg::KNOB_W-1:0] activation_threshold_knob_in,
  input  wire logic                        jumper_soc_mgr_in,
  input  wire logic                        jumper_solar_mgr_in,
  input  wire logic                        jumper_buzzer_in,
  input  wire logic                        button_in,
  // Unused input, then outputs
  input  wire logic                        unused_dummy_in,
  output logic                             load_on_out,
  output logic                             buzzer_out,
  output logic                             gen_mode_out,
  output logic                             data_ok_out,
  output logic                             warning_out,
  output logic                             config_error_out
);
  import clls_pkg::*;

  typedef struct packed {
    logic [2:0]          btn_s;
    logic [2:0]          jb_s;
    logic [2:0]          jsoc_s;
    logic [2:0]          jsol_s;
    logic [KNOB_W-1:0]   k1_a, k1_b, k1_c;
    logic [KNOB_W-1:0]   k2_a, k2_b, k2_c;
    logic [KNOB_W-1:0]   k1_r, k2_r;
    logic                btn_r, jb_r, jsoc_r, jsol_r;
    logic [PKT_BITS-1:0] cand_r;
    logic [1:0]          rep_r;
    logic [SOC_W-1:0]    soc_r;
    logic                valid_r;
    logic [CNT_W-1:0]    loss_cnt_r;
    logic [3:0]          loss_int_r;
    logic                auto_on_r;
    logic                blocked_r;
    logic                manual_r;
    logic                started_r;
    logic                warn_r;
    logic [3:0]          warn_n_r;
    logic [CNT_W-1:0]    warn_cnt_r;
    logic [CNT_W-1:0]    beep_cnt_r;
    logic                load_r;
    logic                buz_r;
    logic                gen_r;
    logic                err_r;
    logic [2:0]          fill_r;
  } clls_state_t;

  clls_state_t s_r, s_nxt;

  logic                   btn_press;
  logic                   cfg_err;
  logic                   soc_mode;
  logic [PKT_BITS-1:0]    pkt_word;
  logic [SOC_W-1:0]       off_lvl;
  logic [SOC_W-1:0]       on_lvl;
  logic                   below_off;
  logic                   above_on;
  logic                   knob_step;

  always_comb begin
    s_nxt = s_r;

    // Three-stage input sync; change counts when stages 2 and 3 agree
    s_nxt.btn_s  = {s_r.btn_s[1:0], button_in};
    s_nxt.jb_s   = {s_r.jb_s[1:0], jumper_buzzer_in};
    s_nxt.jsoc_s = {s_r.jsoc_s[1:0], jumper_soc_mgr_in};
    s_nxt.jsol_s = {s_r.jsol_s[1:0], jumper_solar_mgr_in};
    s_nxt.k1_a   = shutdown_threshold_knob_in;
    s_nxt.k1_b   = s_r.k1_a;
    s_nxt.k1_c   = s_r.k1_b;
    s_nxt.k2_a   = activation_threshold_knob_in;
    s_nxt.k2_b   = s_r.k2_a;
    s_nxt.k2_c   = s_r.k2_b;
    // Pins load silently until the syncs hold real values: no false beep
    if (s_r.fill_r != 3'h4) begin
      s_nxt.fill_r = s_r.fill_r + 3'h1;
    end
    if (s_r.btn_s[1] == s_r.btn_s[2]) begin
      s_nxt.btn_r = s_r.btn_s[2];
    end
    if (s_r.jsoc_s[1] == s_r.jsoc_s[2]) begin
      s_nxt.jsoc_r = s_r.jsoc_s[2];
    end
    if (s_r.jsol_s[1] == s_r.jsol_s[2]) begin
      s_nxt.jsol_r = s_r.jsol_s[2];
    end
    btn_press = s_nxt.btn_r & ~s_r.btn_r;

    // Knobs and buzzer jumper frozen during the warning phase; mode jumpers are not
    knob_step = 1'b0;
    if (!s_r.warn_r) begin
      if (s_r.jb_s[1] == s_r.jb_s[2]) begin
        s_nxt.jb_r = s_r.jb_s[2];
      end
      if (s_r.k1_b == s_r.k1_c && s_r.k1_c != s_r.k1_r) begin
        s_nxt.k1_r = s_r.k1_c;
        knob_step  = (s_r.fill_r == 3'h4);
      end
      if (s_r.k2_b == s_r.k2_c && s_r.k2_c != s_r.k2_r) begin
        s_nxt.k2_r = s_r.k2_c;
        knob_step  = (s_r.fill_r == 3'h4);
      end
    end

    // Equal knobs, out-of-range knobs or no/both mode jumpers
    cfg_err = (s_r.fill_r == 3'h4) &&
              ((s_r.k1_r == s_r.k2_r) || (s_r.k1_r > KNOB_MAX) ||
               (s_r.k2_r > KNOB_MAX) || (s_r.jsoc_r == s_r.jsol_r));
    soc_mode = s_r.jsoc_r && (s_r.k1_r < s_r.k2_r);
    s_nxt.gen_r = s_r.jsoc_r && (s_r.k1_r > s_r.k2_r);
    s_nxt.err_r = cfg_err;

    // Packet acceptance after three matching error-free receptions
    pkt_word = {pkt_soc_in, pkt_gen_id_in, pkt_surplus_id_in, pkt_day_in};
    if (pkt_valid_in && !pkt_error_in) begin
      s_nxt.loss_cnt_r = '0;
      s_nxt.loss_int_r = '0;
      if (pkt_word != s_r.cand_r || s_r.rep_r == 2'h0) begin
        s_nxt.cand_r = pkt_word;
        s_nxt.rep_r  = 2'h1;
      end else if (s_r.rep_r != REPEAT_NEED) begin
        s_nxt.rep_r = s_r.rep_r + 2'h1;
      end
      if (pkt_word == s_r.cand_r && s_r.rep_r >= REPEAT_NEED - 2'h1) begin
        s_nxt.soc_r   = pkt_soc_in;
        s_nxt.valid_r = 1'b1;
      end
    end else if (s_r.loss_cnt_r == CNT_W'(PKT_INTERVAL_CYC - 1)) begin
      s_nxt.loss_cnt_r = '0;
      if (s_r.loss_int_r == LOSS_INTERVALS - 4'h1) begin
        s_nxt.valid_r = 1'b0;
        s_nxt.rep_r   = 2'h0;
      end else begin
        s_nxt.loss_int_r = s_r.loss_int_r + 4'h1;
      end
    end else begin
      s_nxt.loss_cnt_r = s_r.loss_cnt_r + CNT_W'(1);
    end

    off_lvl   = SOC_W'({3'h0, s_r.k1_r} + 7'h1) * SOC_STEP;
    on_lvl    = SOC_W'({3'h0, s_r.k2_r}) * SOC_STEP;
    below_off = s_r.soc_r < off_lvl;
    above_on  = s_r.soc_r >= on_lvl;

    // Automatic decision with hysteresis
    if (!s_r.valid_r || !soc_mode) begin
      s_nxt.auto_on_r = 1'b1;
      s_nxt.blocked_r = 1'b0;
      s_nxt.warn_r    = 1'b0;
    end else if (!s_r.started_r) begin
      s_nxt.started_r = 1'b1;
      s_nxt.auto_on_r = !below_off || above_on;
      s_nxt.blocked_r = below_off && !above_on;
    end else if (s_r.warn_r) begin
      if (s_r.warn_cnt_r == CNT_W'(WARN_GAP_CYC - 1)) begin
        s_nxt.warn_cnt_r = '0;
        s_nxt.warn_n_r   = s_r.warn_n_r + 4'h1;
        s_nxt.beep_cnt_r = CNT_W'(BEEP_CYC);
        if (s_r.warn_n_r == WARN_BEEPS - 4'h1) begin
          s_nxt.warn_r    = 1'b0;
          s_nxt.auto_on_r = 1'b0;
          s_nxt.blocked_r = 1'b1;
          s_nxt.manual_r  = 1'b0;
        end
      end else begin
        s_nxt.warn_cnt_r = s_r.warn_cnt_r + CNT_W'(1);
      end
    end else if (s_r.blocked_r) begin
      if (above_on) begin
        s_nxt.blocked_r = 1'b0;
        s_nxt.auto_on_r = 1'b1;
      end
    end else if (below_off) begin
      if (s_r.jb_r && s_r.load_r) begin
        s_nxt.warn_r     = 1'b1;
        s_nxt.warn_n_r   = '0;
        s_nxt.warn_cnt_r = '0;
        s_nxt.beep_cnt_r = CNT_W'(BEEP_CYC);
      end else begin
        s_nxt.auto_on_r = 1'b0;
        s_nxt.blocked_r = 1'b1;
        s_nxt.manual_r  = 1'b0;
      end
    end
    if (!s_r.valid_r) begin
      s_nxt.started_r = 1'b0;
    end

    // Button toggles when not blocked, data or not
    if (btn_press && !s_r.blocked_r) begin
      s_nxt.manual_r = ~s_r.manual_r;
    end

    if (s_r.blocked_r) begin
      s_nxt.load_r = s_r.btn_r;
    end else begin
      s_nxt.load_r = s_r.auto_on_r ^ s_r.manual_r;
    end

    // Beeps: knob steps, warnings; data loss makes no sound
    if (knob_step) begin
      s_nxt.beep_cnt_r = CNT_W'(BEEP_CYC);
    end else if (s_r.beep_cnt_r != '0 && s_nxt.beep_cnt_r == s_r.beep_cnt_r) begin
      s_nxt.beep_cnt_r = s_r.beep_cnt_r - CNT_W'(1);
    end
    s_nxt.buz_r = cfg_err || (s_r.beep_cnt_r != '0);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign load_on_out      = s_r.load_r;
  assign buzzer_out       = s_r.buz_r;
  assign gen_mode_out     = s_r.gen_r;
  assign data_ok_out      = s_r.valid_r;
  assign warning_out      = s_r.warn_r;
  assign config_error_out = s_r.err_r;

endmodule // clls_load_switch

/* File: design/clls_pkg.sv */
// Package for the charge-level load switch: field widths, thresholds,
// and timing counts. Assumes a 100 MHz system clock.
package clls_pkg;

  localparam int          CLK_HZ            = 100_000_000;
  localparam int          SOC_W             = 7;
  localparam int          KNOB_W            = 4;
  localparam int          ID_W              = 4;
  localparam logic [3:0]  KNOB_MAX          = 4'h9;
  localparam logic [6:0]  SOC_STEP          = 7'h0a;
  localparam logic [1:0]  REPEAT_NEED       = 2'h3;
  localparam int          PKT_BITS          = SOC_W + ID_W + ID_W + 1;

  // Warning phase: a beep at the start, then ten more over about one minute
  localparam int          WARN_TOTAL_S      = 60;
  localparam logic [3:0]  WARN_BEEPS        = 4'ha;
  localparam int          WARN_GAP_MS       = WARN_TOTAL_S * 1000 / 10;
  localparam longint      WARN_GAP_CYC      = longint'(WARN_GAP_MS) * (CLK_HZ / 1000);

  // Short beep length for knob steps and warning beeps
  localparam int          BEEP_MS           = 100;
  localparam int          BEEP_CYC          = BEEP_MS * (CLK_HZ / 1000);

  // Expected packet interval about one minute
  localparam int          PKT_INTERVAL_S    = 60;
  localparam longint      PKT_INTERVAL_CYC  = longint'(PKT_INTERVAL_S) * CLK_HZ;
  localparam logic [3:0]  LOSS_INTERVALS    = 4'h3;

  // Input filter: button and jumper settle time
  localparam int          DEBOUNCE_MS       = 20;
  localparam int          DEBOUNCE_CYC      = DEBOUNCE_MS * (CLK_HZ / 1000);

  localparam int          CNT_W             = 36;

endpackage : clls_pkg

/* File: verification/clls_ctrl_model.sv */
// Charge controller transmitter model: one framed packet per send.
// Assumes the line receiver hands packets over on clk_in.
`timescale 1ns/1ps
module clls_ctrl_model #(
  parameter int GAP = 4
) (
  // Clock and transmit setting
  input  wire logic  clk_in,
  input  wire logic  battery_transmit_setting_in,
  // Framed packet
  output logic       pkt_valid_out,
  output logic       pkt_error_out,
  output logic [6:0] pkt_soc_out,
  output logic [3:0] pkt_gen_id_out,
  output logic [3:0] pkt_surplus_id_out,
  output logic       pkt_day_out
);
  initial begin
    pkt_valid_out = 1'b0;
    {pkt_error_out, pkt_soc_out, pkt_gen_id_out, pkt_surplus_id_out, pkt_day_out} = '0;
  end
  // Real spacing is a minute; short gap keeps the run short
  task automatic send(input logic [6:0] soc, input logic [3:0] gid, input logic bad);
    if (!battery_transmit_setting_in) return;
    @(posedge clk_in);
    pkt_valid_out <= 1'b1;
    {pkt_error_out, pkt_soc_out, pkt_gen_id_out, pkt_surplus_id_out, pkt_day_out}
      <= {bad, soc, gid, ~gid, 1'b1};
    @(posedge clk_in);
    pkt_valid_out <= 1'b0;
    // Idle lines must not show stale content
    {pkt_error_out, pkt_soc_out, pkt_gen_id_out, pkt_surplus_id_out, pkt_day_out}
      <= ~{bad, soc, gid, ~gid, 1'b1};
    repeat (GAP) @(posedge clk_in);
  endtask
endmodule // clls_ctrl_model

/* File: verification/clls_props.sv */
// Port checker for the charge-level load switch.
// Assumes one clock domain and binding to every design instance.
`timescale 1ns/1ps
module clls_props (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       rst_in,
  // Inputs watched
  input wire logic       pkt_valid_in,
  input wire logic       pkt_error_in,
  input wire logic [3:0] shutdown_threshold_knob_in,
  input wire logic [3:0] activation_threshold_knob_in,
  input wire logic       jumper_soc_mgr_in,
  input wire logic       jumper_solar_mgr_in,
  input wire logic       jumper_buzzer_in,
  // Outputs watched
  input wire logic       load_on_out,
  input wire logic       buzzer_out,
  input wire logic       gen_mode_out,
  input wire logic       data_ok_out,
  input wire logic       warning_out,
  input wire logic       config_error_out
);
  logic sok;
  logic shi;
  logic eqk;
  assign sok = jumper_soc_mgr_in && !jumper_solar_mgr_in;
  assign shi = shutdown_threshold_knob_in > activation_threshold_knob_in;
  assign eqk = shutdown_threshold_knob_in == activation_threshold_knob_in;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  reset_quiet_a: assert property (disable iff (1'b0) rst_in |=> !(load_on_out || buzzer_out
    || gen_mode_out || data_ok_out || warning_out || config_error_out)) else $error("output active after reset");
  accept_edge_a: assert property ($rose(data_ok_out) |-> $past(pkt_valid_in && !pkt_error_in))
    else $error("data accepted without a good packet");
  cfg_equal_a: assert property ((sok && eqk && !warning_out)[*8] |=> config_error_out)
    else $error("equal knobs not flagged");
  gen_on_a: assert property ((sok && shi)[*8] |=> gen_mode_out)
    else $error("generator mode missing");
  gen_off_a: assert property ((!shi)[*8] |=> !gen_mode_out)
    else $error("generator mode with low shutdown knob");
  warn_jumper_a: assert property ((!jumper_buzzer_in)[*8] ##1 !warning_out |=> !warning_out)
    else $error("warning without buzzer jumper");
  cfg_buzz_a: assert property (config_error_out[*3] |-> buzzer_out)
    else $error("config error buzzer silent");
  knob_beep_a: assert property ($changed(shutdown_threshold_knob_in) && !warning_out
    |-> ##[1:8] buzzer_out) else $error("knob step without beep");
endmodule // clls_props
bind clls_load_switch clls_props clls_props_inst (.clk_sys_in, .rst_in, .pkt_valid_in, .pkt_error_in,
  .shutdown_threshold_knob_in, .activation_threshold_knob_in, .jumper_soc_mgr_in,
  .jumper_solar_mgr_in, .jumper_buzzer_in, .load_on_out, .buzzer_out, .gen_mode_out,
  .data_ok_out, .warning_out, .config_error_out);

/* File: verification/tb_top.sv */
// Self-checking bench for the charge-level load switch.
// Assumes clls_ctrl_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_top;
  logic       clk_sys_in = 1'b0;
  logic       rst_in     = 1'b1;
  logic       tx_en      = 1'b1;
  logic [3:0] shut_k     = 4'h2;
  logic [3:0] act_k      = 4'h5;
  logic       sol_j      = 1'b0;
  logic       btn        = 1'b0;
  logic       pv, pe, pd, load, buz, gen, dok, warn, cerr;
  logic [6:0] ps, s;
  logic [3:0] pg, pu, gid;
  logic [7:0] n;
  logic [7:0] exp_q[$];
  int         fail_count = 0;
  int         checks_done = 0;
  event       look;
  initial forever #5 clk_sys_in = ~clk_sys_in;
  clls_ctrl_model clls_ctrl_model_inst (.clk_in(clk_sys_in), .battery_transmit_setting_in(tx_en),
    .pkt_valid_out(pv), .pkt_error_out(pe), .pkt_soc_out(ps), .pkt_gen_id_out(pg),
    .pkt_surplus_id_out(pu), .pkt_day_out(pd));
  clls_load_switch clls_load_switch_inst (.clk_sys_in, .rst_in, .pkt_valid_in(pv),
    .pkt_error_in(pe), .pkt_soc_in(ps), .pkt_gen_id_in(pg), .pkt_surplus_id_in(pu),
    .pkt_day_in(pd), .shutdown_threshold_knob_in(shut_k), .activation_threshold_knob_in(act_k),
    .jumper_soc_mgr_in(1'b1), .jumper_solar_mgr_in(sol_j), .jumper_buzzer_in(1'b0),
    .button_in(btn), .unused_dummy_in(1'b0), .load_on_out(load), .buzzer_out(buz),
    .gen_mode_out(gen), .data_ok_out(dok), .warning_out(warn), .config_error_out(cerr));
  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    checks_done++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] %0t outputs %b expected %b", $time, seen, want);
    end
  endtask
  // Expected {data_ok, load, config_error, gen_mode} under a mask
  task automatic note(input logic [3:0] e, input logic [3:0] m);
    repeat (12) @(posedge clk_sys_in);
    exp_q.push_back({m, e});
    @(negedge clk_sys_in);
    -> look;
  endtask
  task automatic burst(input logic [6:0] soc, input int k);
    repeat (k) clls_ctrl_model_inst.send(soc, gid, 1'b0);
  endtask
  always @(look) begin
    n = exp_q.pop_front();
    check({dok, load, cerr, gen} & n[7:4], n[3:0] & n[7:4]);
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Whole sequence needs well under 2000 cycles
  initial begin
    #50us;
    fail_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(31161));
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    note(4'b0100, 4'hf);
    check({2'b00, warn, buz}, 4'b0000);
    gid = 4'($urandom());
    s = 7'(30 + $urandom() % 70);
    burst(s, 2);
    clls_ctrl_model_inst.send(s, gid, 1'b1);
    note(4'b0100, 4'hf);
    burst(s, 1);
    note(4'b1100, 4'hf);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys_in);
      btn <= 1'b1;
      repeat (10) @(posedge clk_sys_in);
      btn <= 1'b0;
      note({1'b1, i[0], 2'b00}, 4'hf);
    end
    burst(7'h14, 2);
    burst(7'h15, 2);
    note(4'b1100, 4'hf);
    burst(7'h15, 1);
    note(4'b1000, 4'hf);
    @(posedge clk_sys_in);
    shut_k <= 4'h1;
    burst(7'h19, 3);
    note(4'b1000, 4'hf);
    burst(7'h31, 3);
    note(4'b1000, 4'hf);
    burst(7'h32, 3);
    note(4'b1100, 4'hf);
    @(posedge clk_sys_in);
    shut_k <= 4'h5;
    note(4'b0010, 4'b0011);
    @(posedge clk_sys_in);
    shut_k <= 4'h7;
    note(4'b0001, 4'b0011);
    @(posedge clk_sys_in);
    sol_j <= 1'b1;
    note(4'b0010, 4'b0010);
    check({2'b00, warn, buz}, 4'b0001);
    give_verdict();
  end
endmodule // tb_top
